// *** hdl/strap_mux_pkg.sv ***
// Shared constants for the strap latch and pin function block
package strap_mux_pkg;
  // Reset phase of the pin logic
  typedef enum logic [1:0] {
    ST_RESET = 2'b01,
    ST_RUN = 2'b10
  } phase_t;
  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  // Register offsets
  localparam addr_t OFS_REF_A_CONFIG = 8'h00;
  localparam addr_t OFS_REF_B_CONFIG = 8'h01;
  localparam addr_t OFS_MASTER_CONFIG_1 = 8'h02;
  localparam addr_t OFS_MASTER_CONFIG_3 = 8'h03;
  localparam addr_t OFS_MASTER_CONFIG_6 = 8'h04;
  localparam addr_t OFS_MASTER_CONFIG_8 = 8'h05;
  localparam addr_t OFS_MASTER_CONFIG_10 = 8'h06;
  localparam addr_t OFS_MASTER_STATUS_2 = 8'h07;
  localparam addr_t OFS_FRAME_PULSE_CONFIG = 8'h08;
  localparam addr_t OFS_GP_IO_CONTROL = 8'h09;
  localparam addr_t OFS_GP_IO_STATE = 8'h0a;
  localparam addr_t OFS_IRQ_PIN_CONFIG = 8'h0b;
  localparam addr_t OFS_SE_OUT_RATE = 8'h0c;
  localparam addr_t OFS_DIFF_OUT_RATE = 8'h0d;
  // Field positions of irq_pin_config
  localparam int IRQ_ABSENT_MODE = 0;
  localparam int IRQ_ACTIVE_HIGH = 1;
  localparam int IRQ_OPEN_DRAIN = 2;
  localparam int IRQ_GP_MODE = 3;
  localparam int IRQ_GP_VALUE = 4;
  localparam int IRQ_CFG_W = 5;
  // Field positions of frame_pulse_config
  localparam int FP_FRAME_INVERT = 0;
  localparam int FP_FRAME_SHAPE = 1;
  localparam int FP_MFRAME_INVERT = 2;
  localparam int FP_MFRAME_SHAPE = 3;
  // Strap widths and the synchronised strap vector layout
  localparam int RATE_STRAP_W = 3;
  localparam int RATE_CODE_W = 4;
  localparam int GP_W = 4;
  localparam int STRAP_W = 10;
  localparam int SV_INPUT = 0;
  localparam int SV_SE = 3;
  localparam int SV_DIFF = 6;
  localparam int SV_FAMILY = 9;
  // Frame timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FRAME_PERIOD_NS = 125000;
  localparam int MFRAME_PERIOD_NS = 500000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MFRAME_CYCLES = MFRAME_PERIOD_NS / CLK_PERIOD_NS;
endpackage : strap_mux_pkg

// *** hdl/frame_cfg_if.sv ***
// Settings and output of one frame pulse generator
interface frame_cfg_if;
  logic invert;
  logic shape;
  logic pulse;
  modport ctl (output invert, output shape, input pulse);
  modport gen (input invert, input shape, output pulse);
endinterface : frame_cfg_if

// *** hdl/strap_sync.sv ***
// Two-stage synchroniser for strap and shared pin levels
module strap_sync #(
  parameter int WIDTH = 10
) (
  // Clock
  input wire logic ref_clk,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import strap_mux_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_t;
  sync_t s_q;
  sync_t s_d;
  // No reset here so the levels seen during reset are ready at release
  always_comb begin
    s_d.meta = din;
    s_d.held = s_q.meta;
  end
  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end
  assign dout = s_q.held;
endmodule : strap_sync

// *** hdl/frame_pulse_gen.sv ***
// Frame or multiframe clock and pulse generator
module frame_pulse_gen #(
  parameter int PERIOD = 1250
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Settings and output
  frame_cfg_if.gen cfg
);
  import strap_mux_pkg::*;
  localparam int CW = $clog2(PERIOD);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
  } gen_t;
  gen_t s_q;
  gen_t s_d;
  logic raw;
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == CW'(PERIOD - 1)) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
    // Clock mode is high for the first half; pulse mode is one cycle wide
    raw = cfg.shape ? (s_d.cnt == '0) : (s_d.cnt < CW'(PERIOD / 2));
    s_d.level = raw ^ cfg.invert;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // Counter parks at its last count so the output is low in reset and a period starts on release
      s_q.cnt <= CW'(PERIOD - 1);
      s_q.level <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end
  assign cfg.pulse = s_q.level;

  AST_FRAME_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_q.cnt == '0 && $stable(cfg.invert)) |-> (s_q.level == !cfg.invert))
    else $error("frame output wrong at period start");
  AST_FRAME_HALF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s_q.cnt == CW'(PERIOD / 2) && $stable(cfg.invert)) |-> (s_q.level == cfg.invert))
    else $error("frame output wrong at half period");
endmodule : frame_pulse_gen

// *** hdl/strap_pin_mux.sv ***
// Strap latch, shared pin functions and register file of the timing device pins
//
// Strobed register access and the register offsets were decided locally.
module strap_pin_mux #(
  parameter int FRAME_PERIOD = strap_mux_pkg::FRAME_CYCLES,
  parameter int MFRAME_PERIOD = strap_mux_pkg::MFRAME_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire strap_mux_pkg::addr_t regAddr,
  input wire strap_mux_pkg::data_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output strap_mux_pkg::data_t regRdata,
  // Dedicated straps
  input wire logic [2:0] inputRateStraps,
  input wire logic seOutRateStrap0,
  // Shared strap pins: se rate 1 / ref fail, se rate 2 / lock
  input wire logic refFailPinIn,
  output logic refFailPinOut,
  output logic refFailPinOe,
  input wire logic lockPinIn,
  output logic lockPinOut,
  output logic lockPinOe,
  // Shared strap pins: diff rate 0..2 and rate family / gpio 1..4
  input wire logic [3:0] gpPinIn,
  output logic [3:0] gpPinOut,
  output logic [3:0] gpPinOe,
  // Reference selection and monitors
  input wire logic sourceSelectPin,
  input wire logic refAActive,
  input wire logic refBActive,
  input wire logic dpllLocked,
  output logic selRefIsA,
  // Interrupt request / reference absent pin
  input wire logic irqPending,
  output logic irqOutPin,
  output logic irqOutOe,
  // Frame outputs
  output logic framePulseOut,
  output logic multiframePulseOut,
  // Configuration to the clock core
  output logic [3:0] refARateCode,
  output logic [3:0] refBRateCode,
  output logic [2:0] seOutRate,
  output logic [2:0] diffOutRate,
  output logic [1:0] diffOutSignalFormat,
  output logic rateFamilySelect,
  output logic digitalRateFamily1,
  output logic digitalRateFamily2,
  // Serial port pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic cpha,
  output logic sdo,
  // Serial bit stream to the framing logic
  input wire logic txBit,
  output logic rxBit,
  output logic rxValid
);
  import strap_mux_pkg::*;

  typedef struct packed {
    phase_t phase;
    logic [RATE_CODE_W-1:0] refA;
    logic [RATE_CODE_W-1:0] refB;
    logic lockEn;
    logic rateFam;
    logic dig1;
    logic dig2;
    logic [1:0] diffFmt;
    logic srfEn;
    logic [3:0] fpCfg;
    logic [GP_W-1:0] gpDir;
    logic [GP_W-1:0] gpVal;
    logic [IRQ_CFG_W-1:0] irqCfg;
    logic [RATE_STRAP_W-1:0] seRate;
    logic [RATE_STRAP_W-1:0] diffRate;
    data_t rdData;
    logic sdo;
    logic sclkPrev;
    logic rxBit;
    logic rxValid;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [STRAP_W-1:0] strapRaw;
  logic [STRAP_W-1:0] strapSync;
  logic running;
  logic selFail;
  logic lead;
  logic trail;
  logic capture;
  logic launch;
  logic irqLevel;
  frame_cfg_if frameIf ();
  frame_cfg_if mframeIf ();

  // Straps and shared pin levels share one synchroniser
  assign strapRaw = {gpPinIn[3], gpPinIn[2:0], lockPinIn, refFailPinIn, seOutRateStrap0,
                     inputRateStraps};

  strap_sync #(
    .WIDTH(STRAP_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .din(strapRaw),
    .dout(strapSync)
  );

  frame_pulse_gen #(
    .PERIOD(FRAME_PERIOD)
  ) u_frame (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cfg(frameIf)
  );

  frame_pulse_gen #(
    .PERIOD(MFRAME_PERIOD)
  ) u_mframe (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cfg(mframeIf)
  );

  assign frameIf.invert = s_q.fpCfg[FP_FRAME_INVERT];
  assign frameIf.shape = s_q.fpCfg[FP_FRAME_SHAPE];
  assign mframeIf.invert = s_q.fpCfg[FP_MFRAME_INVERT];
  assign mframeIf.shape = s_q.fpCfg[FP_MFRAME_SHAPE];
  assign framePulseOut = frameIf.pulse;
  assign multiframePulseOut = mframeIf.pulse;

  assign running = (s_q.phase == ST_RUN);
  assign selRefIsA = sourceSelectPin;
  assign selFail = sourceSelectPin ? !refAActive : !refBActive;

  // Serial clock edges, clock idles low
  assign lead = sclk && !s_q.sclkPrev;
  assign trail = !sclk && s_q.sclkPrev;
  assign capture = cpha ? trail : lead;
  assign launch = cpha ? lead : trail;

  always_comb begin
    s_d = s_q;
    s_d.rxValid = 1'b0;
    s_d.rdData = '0;
    s_d.sclkPrev = sclk;
    case (s_q.phase)
      ST_RESET: begin
        // First edge after release takes the synchronised straps
        s_d.refA = {1'b0, strapSync[SV_INPUT +: RATE_STRAP_W]};
        s_d.refB = {1'b0, strapSync[SV_INPUT +: RATE_STRAP_W]};
        s_d.seRate = strapSync[SV_SE +: RATE_STRAP_W];
        s_d.diffRate = strapSync[SV_DIFF +: RATE_STRAP_W];
        s_d.rateFam = strapSync[SV_FAMILY];
        s_d.dig1 = strapSync[SV_FAMILY];
        s_d.dig2 = strapSync[SV_FAMILY];
        s_d.phase = ST_RUN;
      end
      ST_RUN: begin
        // Straps are not looked at again here
        if (regWr) begin
          case (regAddr)
            OFS_REF_A_CONFIG: s_d.refA = regWdata[RATE_CODE_W-1:0];
            OFS_REF_B_CONFIG: s_d.refB = regWdata[RATE_CODE_W-1:0];
            OFS_MASTER_CONFIG_1: s_d.lockEn = regWdata[0];
            OFS_MASTER_CONFIG_3: s_d.rateFam = regWdata[0];
            OFS_MASTER_CONFIG_6: begin
              s_d.dig1 = regWdata[0];
              s_d.dig2 = regWdata[1];
            end
            OFS_MASTER_CONFIG_8: s_d.diffFmt = regWdata[1:0];
            OFS_MASTER_CONFIG_10: s_d.srfEn = regWdata[0];
            OFS_FRAME_PULSE_CONFIG: s_d.fpCfg = regWdata[3:0];
            OFS_GP_IO_CONTROL: begin
              s_d.gpDir = regWdata[GP_W-1:0];
              s_d.gpVal = regWdata[2*GP_W-1:GP_W];
            end
            OFS_IRQ_PIN_CONFIG: s_d.irqCfg = regWdata[IRQ_CFG_W-1:0];
            OFS_SE_OUT_RATE: s_d.seRate = regWdata[RATE_STRAP_W-1:0];
            OFS_DIFF_OUT_RATE: s_d.diffRate = regWdata[RATE_STRAP_W-1:0];
            default: s_d.phase = ST_RUN;
          endcase
        end
        if (regRd) begin
          case (regAddr)
            OFS_REF_A_CONFIG: s_d.rdData = {4'h0, s_q.refA};
            OFS_REF_B_CONFIG: s_d.rdData = {4'h0, s_q.refB};
            OFS_MASTER_CONFIG_1: s_d.rdData = {7'h00, s_q.lockEn};
            OFS_MASTER_CONFIG_3: s_d.rdData = {7'h00, s_q.rateFam};
            OFS_MASTER_CONFIG_6: s_d.rdData = {6'h00, s_q.dig2, s_q.dig1};
            OFS_MASTER_CONFIG_8: s_d.rdData = {6'h00, s_q.diffFmt};
            OFS_MASTER_CONFIG_10: s_d.rdData = {7'h00, s_q.srfEn};
            OFS_MASTER_STATUS_2: s_d.rdData = {5'h00, sourceSelectPin, dpllLocked, selFail};
            OFS_FRAME_PULSE_CONFIG: s_d.rdData = {4'h0, s_q.fpCfg};
            OFS_GP_IO_CONTROL: s_d.rdData = {s_q.gpVal, s_q.gpDir};
            OFS_GP_IO_STATE: s_d.rdData = {4'h0, strapSync[SV_DIFF +: GP_W]};
            OFS_IRQ_PIN_CONFIG: s_d.rdData = {3'h0, s_q.irqCfg};
            OFS_SE_OUT_RATE: s_d.rdData = {5'h00, s_q.seRate};
            OFS_DIFF_OUT_RATE: s_d.rdData = {5'h00, s_q.diffRate};
            default: s_d.rdData = '0;
          endcase
        end
      end
      default: s_d.phase = ST_RESET;
    endcase
    // The port only moves while the master holds chip select low
    if (!csN && capture) begin
      s_d.rxBit = sdi;
      s_d.rxValid = 1'b1;
    end
    if (!csN && launch) begin
      s_d.sdo = txBit;
    end
  end

  // Synchronous reset; holding it keeps everything at defaults and waits for the straps
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.phase <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Shared pins stay inputs during reset so the straps can be read
  assign refFailPinOut = selFail;
  assign refFailPinOe = running && s_q.srfEn;
  assign lockPinOut = s_q.lockEn && dpllLocked;
  assign lockPinOe = running;
  assign gpPinOut = s_q.gpVal;
  assign gpPinOe = running ? s_q.gpDir : '0;

  // Open drain only ever pulls low, so the enable carries the request
  always_comb begin
    if (s_q.irqCfg[IRQ_GP_MODE]) begin
      irqLevel = s_q.irqCfg[IRQ_GP_VALUE];
    end else begin
      irqLevel = s_q.irqCfg[IRQ_ACTIVE_HIGH] ? irqPending : !irqPending;
    end
    if (s_q.irqCfg[IRQ_ABSENT_MODE]) begin
      irqOutPin = selFail;
      irqOutOe = 1'b1;
    end else if (s_q.irqCfg[IRQ_OPEN_DRAIN]) begin
      irqOutPin = 1'b0;
      irqOutOe = !irqLevel;
    end else begin
      irqOutPin = irqLevel;
      irqOutOe = 1'b1;
    end
  end

  assign regRdata = s_q.rdData;
  assign refARateCode = s_q.refA;
  assign refBRateCode = s_q.refB;
  assign seOutRate = s_q.seRate;
  assign diffOutRate = s_q.diffRate;
  assign diffOutSignalFormat = s_q.diffFmt;
  assign rateFamilySelect = s_q.rateFam;
  assign digitalRateFamily1 = s_q.dig1;
  assign digitalRateFamily2 = s_q.dig2;
  assign sdo = s_q.sdo;
  assign rxBit = s_q.rxBit;
  assign rxValid = s_q.rxValid;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence seqRelease;
    (s_q.phase == ST_RESET) ##1 (s_q.phase == ST_RUN);
  endsequence

  AST_IN_LATCH: assert property (seqRelease |->
    (s_q.refA == {1'b0, $past(strapSync[2:0])}) && (s_q.refB == s_q.refA))
    else $error("input rate code not latched from straps");
  AST_STRAP_HOLD: assert property ((running && !regWr) |=>
    ($stable(s_q.refA) && $stable(s_q.seRate) && $stable(s_q.diffRate)))
    else $error("latched strap value moved without a write");
  AST_SE_LATCH: assert property (seqRelease |-> (seOutRate == $past(strapSync[5:3])))
    else $error("single-ended rate not latched");
  AST_DIFF_LATCH: assert property (seqRelease |-> (diffOutRate == $past(strapSync[8:6])))
    else $error("differential rate not latched");
  AST_FAMILY: assert property (seqRelease |->
    ({rateFamilySelect, digitalRateFamily1, digitalRateFamily2} == {3{$past(strapSync[9])}}))
    else $error("rate family not latched");
  // Read paths are checked one cycle after the strobe, where the data stand
  AST_SELECT: assert property ((running && regRd && regAddr == OFS_MASTER_STATUS_2) |=>
    (regRdata[2:0] == {$past(sourceSelectPin), $past(dpllLocked),
    ($past(sourceSelectPin) ? !$past(refAActive) : !$past(refBActive))}))
    else $error("status read does not follow the selected reference");
  AST_FAIL_PIN: assert property (running |->
    (refFailPinOe == s_q.srfEn) && (refFailPinOut == selFail))
    else $error("fail pin wrong");
  AST_LOCK_PIN: assert property (running |-> lockPinOe && (lockPinOut == (s_q.lockEn && dpllLocked)))
    else $error("lock pin wrong");
  AST_GP_DIR: assert property ((regWr && running && regAddr == OFS_GP_IO_CONTROL) |=>
    (gpPinOe == $past(regWdata[3:0])) && (gpPinOut == $past(regWdata[7:4])))
    else $error("gpio control write not applied");
  AST_ABSENT_MODE: assert property (s_q.irqCfg[IRQ_ABSENT_MODE] |-> irqOutOe && (irqOutPin == selFail))
    else $error("irq pin not in absent mode");
  AST_SERIAL_CAP: assert property ((!csN && capture) |=> rxValid && (rxBit == $past(sdi)))
    else $error("serial bit not captured");
  // Shared pin drivers stay off until the straps are latched, or a strap would read back its own drive
  AST_PINS_QUIET: assert property ((s_q.phase == ST_RESET) |->
    (gpPinOe == '0) && !refFailPinOe && !lockPinOe)
    else $error("shared pin driven before straps latched");
  AST_GP_STATE: assert property ((running && regRd && regAddr == OFS_GP_IO_STATE) |=>
    (regRdata == {4'h0, $past(strapSync[SV_DIFF +: GP_W])}))
    else $error("gpio state read wrong");
  AST_FORMAT: assert property ((running && regWr && regAddr == OFS_MASTER_CONFIG_8) |=>
    (diffOutSignalFormat == $past(regWdata[1:0])))
    else $error("signal format write not applied");
  AST_OPEN_DRAIN: assert property
    ((!s_q.irqCfg[IRQ_ABSENT_MODE] && s_q.irqCfg[IRQ_OPEN_DRAIN]) |-> !irqOutPin)
    else $error("open drain pin drives high");
endmodule : strap_pin_mux

// *** testbench/board_pins.sv ***
// Board model: strap resistors, pin pulls and an outside driver on the four gpio pins
module board_pins (
  // Board settings
  input wire logic strapOn,
  input wire logic [9:0] strapVal,
  input wire logic [3:0] extOn,
  input wire logic [3:0] extVal,
  // Device pin drivers
  input wire logic refFailPinOut,
  input wire logic refFailPinOe,
  input wire logic lockPinOut,
  input wire logic lockPinOe,
  input wire logic [3:0] gpPinOut,
  input wire logic [3:0] gpPinOe,
  // Resolved pin levels
  output logic [2:0] inputRateStraps,
  output logic seOutRateStrap0,
  output logic refFailPinIn,
  output logic lockPinIn,
  output logic [3:0] gpPinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Internal pulls of each strap pin, so an open board still gives a defined code
  localparam logic [9:0] PULL = {1'b0, 3'b100, 3'b011, 3'b000};
  logic [9:0] board;
  assign board = strapOn ? strapVal : PULL;
  assign inputRateStraps = board[2:0];
  assign seOutRateStrap0 = board[3];
  // Strap resistors are weak: a driving device pin always wins
  assign refFailPinIn = refFailPinOe ? refFailPinOut : board[4];
  assign lockPinIn = lockPinOe ? lockPinOut : board[5];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gpPinIn[i] = gpPinOe[i] ? gpPinOut[i] : (extOn[i] ? extVal[i] : board[6 + i]);
    end
  end
endmodule : board_pins

// *** testbench/strap_pin_mux_tb_top.sv ***
// Self-checking bench for the strap latch and pin function block
module strap_pin_mux_tb_top import strap_mux_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  // Short frame periods keep the run brief
  localparam int FP = 10;
  localparam int MP = 40;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  addr_t regAddr = '0;
  data_t regWdata = '0;
  data_t regRdata;
  logic regWr = 1'b0, regRd = 1'b0, sourceSelectPin = 1'b0, refAActive = 1'b0;
  logic refBActive = 1'b0, dpllLocked = 1'b0, irqPending = 1'b0, csN = 1'b1, sclk = 1'b0;
  logic sdi = 1'b0, cpha = 1'b0, txBit = 1'b0, strapOn = 1'b0;
  logic [9:0] strapVal = '0;
  logic [3:0] extOn = '0, extVal = '0;
  logic [2:0] inputRateStraps, seOutRate, diffOutRate;
  logic [3:0] gpPinIn, gpPinOut, gpPinOe, refARateCode, refBRateCode;
  logic [1:0] diffOutSignalFormat;
  logic seOutRateStrap0, refFailPinIn, refFailPinOut, refFailPinOe, lockPinIn, lockPinOut;
  logic lockPinOe, selRefIsA, irqOutPin, irqOutOe, framePulseOut, multiframePulseOut;
  logic rateFamilySelect, digitalRateFamily1, digitalRateFamily2, sdo, rxBit, rxValid;
  int err_count = 0;
  int checks_done = 0;

  strap_pin_mux #(.FRAME_PERIOD(FP), .MFRAME_PERIOD(MP)) uut (
    .ref_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .inputRateStraps,
    .seOutRateStrap0, .refFailPinIn, .refFailPinOut, .refFailPinOe, .lockPinIn, .lockPinOut,
    .lockPinOe, .gpPinIn, .gpPinOut, .gpPinOe, .sourceSelectPin, .refAActive, .refBActive,
    .dpllLocked, .selRefIsA, .irqPending, .irqOutPin, .irqOutOe, .framePulseOut,
    .multiframePulseOut, .refARateCode, .refBRateCode, .seOutRate, .diffOutRate,
    .diffOutSignalFormat, .rateFamilySelect, .digitalRateFamily1, .digitalRateFamily2, .csN,
    .sclk, .sdi, .cpha, .sdo, .txBit, .rxBit, .rxValid);
  board_pins board (.strapOn, .strapVal, .extOn, .extVal, .refFailPinOut, .refFailPinOe,
    .lockPinOut, .lockPinOe, .gpPinOut, .gpPinOe, .inputRateStraps, .seOutRateStrap0,
    .refFailPinIn, .lockPinIn, .gpPinIn);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // A hang anywhere ends the run as a failure
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic reg_wr(input addr_t a, input data_t d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input addr_t a, input data_t exp);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(regRdata, exp, "register read");
  endtask : rd_chk

  function automatic logic [1:0] irq_exp(input logic [4:0] c, input logic p, input logic f);
    logic lvl;
    lvl = c[3] ? c[4] : (c[1] ? p : !p);
    if (c[0]) return {1'b1, f};
    if (c[2]) return {!lvl, 1'b0};
    return {1'b1, lvl};
  endfunction : irq_exp

  task automatic do_reset(input bit open);
    if (!sys_rst) begin
      @(posedge ref_clk);
      sys_rst <= 1'b1;
    end
    @(posedge ref_clk);
    strapOn <= !open;
    strapVal <= 10'($urandom);
    tick(1);
    check({2'h0, gpPinOe, refFailPinOe, lockPinOe}, 8'h00, "pin enables in reset");
    check({7'h0, irqOutOe}, 8'h01, "irq enable in reset");
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(3);
  endtask : do_reset

  task automatic straps(input logic [9:0] sv);
    check({4'h0, refARateCode}, {5'h0, sv[2:0]}, "ref a rate");
    check({4'h0, refBRateCode}, {5'h0, sv[2:0]}, "ref b rate");
    check({5'h0, seOutRate}, {5'h0, sv[5:3]}, "se rate");
    check({5'h0, diffOutRate}, {5'h0, sv[8:6]}, "diff rate");
    check({5'h0, rateFamilySelect, digitalRateFamily1, digitalRateFamily2},
      {5'h0, {3{sv[9]}}}, "family");
  endtask : straps

  // Counting over one whole multiframe makes the result independent of phase
  task automatic frames(input logic [1:0] m, input bit wr);
    int f = 0;
    int g = 0;
    if (wr) begin
      reg_wr(OFS_FRAME_PULSE_CONFIG, {4'h0, m, m});
    end
    tick(3);
    for (int i = 0; i < MP; i++) begin
      f += int'(framePulseOut === 1'b1);
      g += int'(multiframePulseOut === 1'b1);
      tick(1);
    end
    check(8'(f), 8'(m[1] ? (m[0] ? MP - MP / FP : MP / FP) : MP / 2), "frame");
    check(8'(g), 8'(m[1] ? (m[0] ? MP - 1 : 1) : MP / 2), "multiframe");
  endtask : frames

  task automatic spi_bit(input logic ph, input logic cs, input logic b, input logic t);
    int hits = 0;
    int late = 0;
    logic r = 1'b0;
    @(posedge ref_clk);
    cpha <= ph;
    csN <= cs;
    sdi <= b;
    txBit <= t;
    tick(3);
    sclk <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      if (i == 6) begin
        sclk <= 1'b0;
      end
      tick(1);
      if (rxValid === 1'b1) begin
        hits++;
        late = int'(i >= 6);
        r = rxBit;
      end
    end
    check({4'h0, 2'(hits), late[0], r}, cs ? 8'h00 : {4'h0, 2'b01, ph, b}, "capture");
    if (!cs) begin
      check({7'h0, sdo}, {7'h0, t}, "serial out");
    end
    csN <= 1'b1;
  endtask : spi_bit

  initial begin
    logic [9:0] sv;
    data_t d, g, e;
    logic fail;
    void'($urandom(92084));
    for (int k = 0; k < 4; k++) begin
      do_reset(k == 0);
      sv = strapOn ? strapVal : {1'b0, 3'b100, 3'b011, 3'b000};
      straps(sv);
      strapOn <= 1'b1;
      strapVal <= ~sv;
      tick(4);
      straps(sv);
      check({6'h0, diffOutSignalFormat}, 8'h00, "format default");
      frames(2'b00, 1'b0);
      frames(2'(k), 1'b1);
      reg_wr(OFS_MASTER_CONFIG_8, 8'(k));
      tick(1);
      check({6'h0, diffOutSignalFormat}, 8'(k), "format");
    end
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      g = 8'($urandom);
      e = 8'($urandom);
      sourceSelectPin <= d[0];
      refAActive <= d[1];
      refBActive <= d[2];
      dpllLocked <= d[3];
      irqPending <= d[4];
      extOn <= ~g[3:0];
      extVal <= e[3:0];
      reg_wr(OFS_MASTER_CONFIG_10, {7'h0, d[5]});
      reg_wr(OFS_MASTER_CONFIG_1, {7'h0, d[6]});
      reg_wr(OFS_IRQ_PIN_CONFIG, {3'h0, d[7], 3'(k), k == 7});
      reg_wr(OFS_GP_IO_CONTROL, g);
      reg_wr(OFS_REF_A_CONFIG, e);
      reg_wr(OFS_MASTER_STATUS_2, 8'hff);
      reg_wr(OFS_REF_B_CONFIG, g);
      reg_wr(OFS_MASTER_CONFIG_3, d);
      reg_wr(OFS_MASTER_CONFIG_6, e);
      reg_wr(OFS_SE_OUT_RATE, g);
      reg_wr(OFS_DIFF_OUT_RATE, e);
      tick(4);
      fail = d[0] ? !d[1] : !d[2];
      check({7'h0, selRefIsA}, {7'h0, d[0]}, "source select");
      check({6'h0, refFailPinOe, refFailPinOe & refFailPinOut},
        {6'h0, d[5], d[5] & fail}, "fail pin");
      check({6'h0, lockPinOe, lockPinOut}, {6'h0, 1'b1, d[6] & d[3]}, "lock pin");
      check({6'h0, irqOutOe, irqOutPin},
        {6'h0, irq_exp({d[7], 3'(k), k == 7}, d[4], fail)}, "irq pin");
      check({4'h0, gpPinOe}, {4'h0, g[3:0]}, "gpio dir");
      check({4'h0, gpPinOut & g[3:0]}, {4'h0, g[7:4] & g[3:0]}, "gpio out");
      rd_chk(OFS_GP_IO_STATE, {4'h0, (g[3:0] & g[7:4]) | (~g[3:0] & e[3:0])});
      rd_chk(OFS_MASTER_STATUS_2, {5'h0, d[0], d[3], fail});
      rd_chk(OFS_GP_IO_CONTROL, g);
      rd_chk(OFS_REF_A_CONFIG, {4'h0, e[3:0]});
      check({4'h0, refARateCode}, {4'h0, e[3:0]}, "ref a code");
      check({4'h0, refBRateCode}, {4'h0, g[3:0]}, "ref b code");
      check({1'h0, seOutRate, 1'b0, diffOutRate}, {1'h0, g[2:0], 1'b0, e[2:0]}, "out rates");
      check({5'h0, rateFamilySelect, digitalRateFamily1, digitalRateFamily2},
        {5'h0, d[0], e[0], e[1]}, "family regs");
      rd_chk(OFS_IRQ_PIN_CONFIG, {3'h0, d[7], 3'(k), k == 7});
      rd_chk(8'h3f, 8'h00);
    end
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      spi_bit(k[0], k == 5, d[0], d[1]);
    end
    finish_test();
  end
endmodule : strap_pin_mux_tb_top
